// ==== ntc_front_end_model.sv ====
// thermistor front end model: sensed resistance against two selected levels
`timescale 1ns/1ps
module ntc_front_end_model (
  input  wire logic [3:0]  low_sel,
  input  wire logic [3:0]  high_sel,
  input  wire logic [31:0] res_ohm,
  output logic             above_low,
  output logic             above_high
);
  // ohms per code; a hotter thermistor reads lower, so below a level means exceeded
  localparam int LVL [16] = '{79670, 43350, 29770, 22670, 18300, 15340, 13210, 11600,
                              10340, 9320, 8490, 7790, 7200, 6690, 6250, 5870};
  assign above_low  = res_ohm < 32'(LVL[low_sel]);
  assign above_high = res_ohm < 32'(LVL[high_sel]);
endmodule : ntc_front_end_model

// ==== tb.sv ====
// self-checking bench for the thermal led current limit block
`timescale 1ns/1ps
module tb;
  logic        clk, rst_n, io_supply_enable, serial_select_n, clk_en;
  logic        ntc_above_low, ntc_above_high, led_off_q, fault_n_q, irq_q;
  logic [7:0]  die_temp_c;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rr, rb;
  logic [15:0] duty_scale_q, current_scale_q;
  logic [3:0]  ntc_low_level_q, ntc_high_level_q;
  logic [31:0] res_ohm, seed, rd;
  int          miscompares, samples_checked, cyc;

  thermal_led_current_limit #(.FILT_CYCLES(3), .STARTUP_CYC(2)) uut (
    .clk, .rst_n, .clk_en, .io_supply_enable, .serial_select_n, .ntc_above_low,
    .ntc_above_high, .die_temp_c, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .duty_scale_q,
    .current_scale_q, .led_off_q, .fault_n_q, .ntc_low_level_q, .ntc_high_level_q, .irq_q);

  ntc_front_end_model fe (.low_sel(ntc_low_level_q), .high_sel(ntc_high_level_q), .res_ohm,
    .above_low(ntc_above_low), .above_high(ntc_above_high));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // reduction expected strictly above the selected die threshold
  function automatic logic die_cut(input logic [7:0] t, input logic [1:0] sel);
    return 32'(t) > 32'd95 + 32'd12 * 32'(sel);
  endfunction : die_cut

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic chk1(input string n, input logic e, input logic g);
    chk(n, {31'd0, e}, {31'd0, g});
  endtask : chk1

  task automatic axw(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do
    begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1);
    rb = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axw

  task automatic axr(input logic [31:0] a);
    @(posedge clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do
    begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axr

  task automatic rchk(input string n, input logic [31:0] a, input logic [31:0] m,
                      input logic [31:0] e);
    axr(a);
    chk(n, e, rd & m);
  endtask : rchk

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : conclude

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ceiling far above the few hundred cycles the sequence needs
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      miscompares++;
      conclude();
    end
  end

  initial
  begin
    {rst_n, io_supply_enable, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    {miscompares, samples_checked, cyc} = '0;
    serial_select_n = 1'b1;
    clk_en = 1'b1;
    die_temp_c = 8'h00;
    res_ohm = 32'd100000;
    seed = 32'h9667;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    chk1("fault_n_reset", 1'b1, fault_n_q);
    rchk("ctrl_reset", 32'h00, 32'hffff_ffff, 32'h0000_f401);
    axr(32'h14);
    chk("unmapped_resp", 32'h2, {30'd0, rr});
    chk("unmapped_data", 32'h0, rd);
    axw(32'h04, 32'h0);
    chk("status_wr_resp", 32'h2, {30'd0, rb});
    res_ohm <= 32'd50000;
    repeat (12) @(posedge clk);
    chk1("fault_standby", 1'b1, fault_n_q);
    rchk("status_standby", 32'h04, 32'hf, 32'h0);
    res_ohm <= 32'd100000;
    io_supply_enable <= 1'b1;
    repeat (12) @(posedge clk);
    chk1("led_off_normal", 1'b0, led_off_q);
    axw(32'h08, 32'h3);
    chk("mask_wr_resp", 32'h0, {30'd0, rb});
    res_ohm <= 32'd50000;
    repeat (3) @(posedge clk);
    chk1("fault_filtered", 1'b1, fault_n_q);
    repeat (9) @(posedge clk);
    chk1("fault_low_flag", 1'b0, fault_n_q);
    chk1("irq_set", 1'b1, irq_q);
    chk("current_low", 32'd5000, 32'(current_scale_q));
    rchk("status_low", 32'h04, 32'hf, 32'h5);
    repeat (2) @(posedge clk);
    chk1("irq_cleared", 1'b0, irq_q);
    axw(32'h10, 32'h1);
    repeat (2) @(posedge clk);
    chk1("fault_release", 1'b1, fault_n_q);
    rchk("flag_held", 32'h04, 32'hc, 32'h4);
    res_ohm <= 32'd100000;
    repeat (8) @(posedge clk);
    serial_select_n <= 1'b0;
    repeat (6) @(posedge clk);
    rchk("flag_select_clr", 32'h04, 32'hc, 32'h0);
    res_ohm <= 32'd5000;
    repeat (12) @(posedge clk);
    chk1("fault_high", 1'b0, fault_n_q);
    chk1("led_off_high", 1'b1, led_off_q);
    rchk("status_high", 32'h04, 32'hc, 32'hc);
    io_supply_enable <= 1'b0;
    res_ohm <= 32'd100000;
    repeat (8) @(posedge clk);
    chk1("fault_en_cycle", 1'b1, fault_n_q);
    rchk("flags_en_cycle", 32'h04, 32'hc, 32'h0);
    io_supply_enable <= 1'b1;
    repeat (12) @(posedge clk);
    axw(32'h00, 32'h0000_f400);
    res_ohm <= 32'd5000;
    repeat (12) @(posedge clk);
    chk1("fault_comp_off", 1'b1, fault_n_q);
    chk1("led_comp_off", 1'b0, led_off_q);
    rchk("status_comp_off", 32'h04, 32'hc, 32'h0);
    res_ohm <= 32'd100000;
    axw(32'h00, 32'h0000_f401);
    die_temp_c <= 8'd120;
    repeat (4) @(posedge clk);
    chk1("duty_cut", 1'b1, duty_scale_q < 16'd10000);
    chk("current_plain", 32'd10000, 32'(current_scale_q));
    die_temp_c <= 8'd96;
    repeat (3) @(posedge clk);
    chk("duty_step", 32'd9775, 32'(duty_scale_q));
    axw(32'h00, 32'h0000_f403);
    for (int i = 0; i < 8; i++)
    begin
      seed = lfsr(seed);
      // avoid the exact threshold where rounding is open
      die_temp_c <= seed[0] ? 8'd70 + 8'(seed[4:1]) : 8'd100 + 8'(seed[4:1]);
      repeat (4) @(posedge clk);
      chk1("duty_rand", die_cut(die_temp_c, 2'd0), duty_scale_q < 16'd10000);
      chk1("current_hybrid", die_cut(die_temp_c, 2'd0), current_scale_q < 16'd10000);
    end
    die_temp_c <= 8'd96;
    repeat (3) @(posedge clk);
    clk_en <= 1'b0;
    die_temp_c <= 8'd130;
    repeat (4) @(posedge clk);
    chk("duty_frozen", 32'd9775, 32'(duty_scale_q));
    clk_en <= 1'b1;
    repeat (3) @(posedge clk);
    chk("duty_resume", 32'd2125, 32'(duty_scale_q));
    chk("current_resume", 32'd2125, 32'(current_scale_q));
    conclude();
  end
endmodule : tb

// ==== thermal_led_current_limit.sv ====
// thermal led current limit with axi4-lite registers
//
// The AXI4-Lite interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "thermal_params.svh"
module thermal_led_current_limit #(
  parameter int FILT_CYCLES  = `NTC_FILT_CYCLES,
  parameter int STARTUP_CYC  = 16
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  input  wire logic        io_supply_enable,
  input  wire logic        serial_select_n,
  input  wire logic        ntc_above_low,
  input  wire logic        ntc_above_high,
  input  wire logic [7:0]  die_temp_c,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [15:0]      duty_scale_q,
  output logic [15:0]      current_scale_q,
  output logic             led_off_q,
  output logic             fault_n_q,
  output logic [3:0]       ntc_low_level_q,
  output logic [3:0]       ntc_high_level_q,
  output logic             irq_q
);
  if (FILT_CYCLES < 1 || FILT_CYCLES > 65535)
  begin : g_bad_filt
    $error("FILT_CYCLES out of range");
  end
  if (STARTUP_CYC < 1 || STARTUP_CYC > 65535)
  begin : g_bad_startup
    $error("STARTUP_CYC out of range");
  end

  // two-flop synchronisers for pins and comparators
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      // select pin idles high; zero here would fake a toggle after reset
      sync1_q <= 4'h4;
      sync2_q <= 4'h4;
    end
    else if (clk_en)
    begin
      sync1_q <= {io_supply_enable, serial_select_n, ntc_above_high, ntc_above_low};
      sync2_q <= sync1_q;
    end
  end
  wire en_s   = sync2_q[3];
  wire sel_s  = sync2_q[2];
  wire high_s = sync2_q[1];
  wire low_s  = sync2_q[0];

  // registers
  logic [31:0] ctrl_q;
  logic [1:0]  status_q;
  logic [1:0]  mask_q;
  logic        sel_q;
  logic        en_q;
  wire comp_en = ctrl_q[`CTRL_COMP_EN];
  wire hybrid  = ctrl_q[`CTRL_HYBRID];
  wire [1:0] die_sel  = ctrl_q[`CTRL_DIE_SEL +: 2];
  wire [3:0] low_sel  = ctrl_q[`CTRL_LOW_SEL +: 4];
  wire [3:0] high_sel = ctrl_q[`CTRL_HIGH_SEL +: 4];

  // operating state: standby while disabled, timed start-up, then normal
  thermal_pkg::op_state_t st_q;
  logic [15:0] st_cnt_q;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q     <= thermal_pkg::ST_STANDBY;
      st_cnt_q <= 16'h0000;
    end
    else if (clk_en)
    begin
      unique case (st_q)
        thermal_pkg::ST_STANDBY:
        begin
          st_cnt_q <= 16'h0000;
          if (en_s)
            st_q <= thermal_pkg::ST_STARTUP;
        end
        thermal_pkg::ST_STARTUP:
        begin
          st_cnt_q <= st_cnt_q + 16'h0001;
          if (!en_s)
            st_q <= thermal_pkg::ST_STANDBY;
          else if (st_cnt_q == 16'(STARTUP_CYC - 1))
            st_q <= thermal_pkg::ST_NORMAL;
        end
        thermal_pkg::ST_NORMAL:
          if (!en_s)
            st_q <= thermal_pkg::ST_STANDBY;
        default:
          st_q <= thermal_pkg::ST_STANDBY;
      endcase
    end
  end
  wire normal = (st_q == thermal_pkg::ST_NORMAL);

  // detection gated by mode and enable, filtered for a fixed time
  wire low_cond  = low_s && normal && comp_en;
  wire high_cond = high_s && normal && comp_en;
  logic [15:0] low_cnt_q;
  logic [15:0] high_cnt_q;
  wire low_hit  = low_cond && (low_cnt_q == 16'(FILT_CYCLES - 1));
  wire high_hit = high_cond && (high_cnt_q == 16'(FILT_CYCLES - 1));
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      low_cnt_q  <= 16'h0000;
      high_cnt_q <= 16'h0000;
    end
    else if (clk_en)
    begin
      low_cnt_q  <= !low_cond ? 16'h0000 : (low_hit ? low_cnt_q : low_cnt_q + 16'h0001);
      high_cnt_q <= !high_cond ? 16'h0000 : (high_hit ? high_cnt_q : high_cnt_q + 16'h0001);
    end
  end

  // flag clearing; select toggle seen as a change on the synced pin
  wire en_fall   = en_q && !en_s;
  wire sel_tog   = sel_q != sel_s;
  // a write is taken at the edge where awready meets both valids still held
  wire aw_go     = s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
  wire aw_hs     = s_axi_awvalid && s_axi_wvalid && s_axi_awready;
  wire clr_cmd   = aw_hs && (s_axi_awaddr[7:0] == `REG_CMD) && s_axi_wstrb[0]
                   && s_axi_wdata[`CMD_CLEAR];
  wire host_clr  = clr_cmd || sel_tog;
  logic low_flag_q;
  logic high_flag_q;
  // flags hold while the condition lasts unless enable falls; a host clear acts only once it has gone
  wire low_flag_d  = en_fall ? 1'b0 : (low_hit || (low_flag_q && !(host_clr && !low_s)));
  wire high_flag_d = en_fall ? 1'b0 : (high_hit || (high_flag_q && !(host_clr && !high_s)));
  wire fault_set   = (low_hit && !low_flag_q) || (high_hit && !high_flag_q);
  // set wins over a host release in the same cycle
  wire fault_n_d   = fault_set ? 1'b0 : ((en_fall || host_clr) ? 1'b1 : fault_n_q);

  // die temperature threshold per select code, duty drop 2.25 %/C in 1/10000 units
  wire [7:0] die_thr = 8'd95 + {die_sel, 3'b000} + {1'b0, die_sel, 2'b00} - 8'h00;
  wire [7:0] over_c  = (die_temp_c > die_thr) ? die_temp_c - die_thr : 8'h00;
  wire [17:0] drop   = 18'(over_c) * 18'(`DUTY_STEP_CENTI);
  wire [15:0] lin_scale = (drop >= 18'd10000) ? 16'h0000 : 16'(18'd10000 - drop);
  wire [15:0] ntc_scale = high_flag_q ? 16'h0000 : (low_flag_q ? 16'd5000 : 16'd10000);
  wire [15:0] duty_d    = (lin_scale < ntc_scale) ? lin_scale : ntc_scale;
  wire [15:0] cur_d     = hybrid ? duty_d : ntc_scale;

  // axi4-lite: ready pulses a cycle after valid, the answer follows the handshake
  wire wr_ctrl = aw_hs && (s_axi_awaddr[7:0] == `REG_CTRL);
  wire wr_mask = aw_hs && (s_axi_awaddr[7:0] == `REG_MASK);
  wire ar_go   = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
  wire ar_hs   = s_axi_arvalid && s_axi_arready;
  wire rd_stat = ar_hs && (s_axi_araddr[7:0] == `REG_STATUS);
  wire [7:0] ra = s_axi_araddr[7:0];
  wire [7:0] wa = s_axi_awaddr[7:0];
  wire w_ok = (wa == `REG_CTRL) || (wa == `REG_MASK) || (wa == `REG_CMD);
  wire r_ok = (ra == `REG_CTRL) || (ra == `REG_STATUS) || (ra == `REG_MASK) || (ra == `REG_TEMP)
              || (ra == `REG_CMD);
  wire [31:0] rmux = (ra == `REG_CTRL)   ? ctrl_q :
                     (ra == `REG_STATUS) ? {28'h0, high_flag_q, low_flag_q, status_q} :
                     (ra == `REG_MASK)   ? {30'h0, mask_q} :
                     (ra == `REG_TEMP)   ? {24'h0, die_temp_c} : 32'h0000_0000;
  wire [31:0] wmask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}}, {8{s_axi_wstrb[1]}},
                       {8{s_axi_wstrb[0]}}};
  // sticky events, cleared by reading status; a new event wins over the read
  wire [1:0] ev = {high_hit && !high_flag_q, low_hit && !low_flag_q};
  wire [1:0] status_d = ev | (rd_stat ? 2'b00 : status_q);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_q <= `CTRL_RESET;
      mask_q <= 2'b00;
      status_q <= 2'b00;
    end
    else if (clk_en)
    begin
      if (wr_ctrl)
        ctrl_q <= (ctrl_q & ~wmask) | (s_axi_wdata & wmask & 32'h0000_0fff);
      if (wr_mask && s_axi_wstrb[0])
        mask_q <= s_axi_wdata[1:0];
      status_q <= status_d;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'b00;
    end
    else if (clk_en)
    begin
      s_axi_awready <= aw_go;
      s_axi_wready  <= aw_go;
      if (aw_hs)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= w_ok ? 2'b00 : 2'b10;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
      s_axi_arready <= ar_go;
      if (ar_hs)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rmux;
        s_axi_rresp  <= r_ok ? 2'b00 : 2'b10;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // flags, fault pin and the scaled outputs
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sel_q <= 1'b1;
      en_q <= 1'b0;
      low_flag_q <= 1'b0;
      high_flag_q <= 1'b0;
      fault_n_q <= 1'b1;
      duty_scale_q <= 16'h0000;
      current_scale_q <= 16'h0000;
      led_off_q <= 1'b1;
      ntc_low_level_q <= 4'h0;
      ntc_high_level_q <= 4'h0;
      irq_q <= 1'b0;
    end
    else if (clk_en)
    begin
      sel_q <= sel_s;
      en_q <= en_s;
      low_flag_q <= low_flag_d;
      high_flag_q <= high_flag_d;
      fault_n_q <= fault_n_d;
      duty_scale_q <= duty_d;
      current_scale_q <= cur_d;
      led_off_q <= high_flag_d || !normal;
      ntc_low_level_q <= low_sel;
      ntc_high_level_q <= high_sel;
      irq_q <= |(status_d & mask_q);
    end
  end

  a_low_filter: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(low_flag_q) && clk_en |-> $past(low_cond) && $past(low_cnt_q) == 16'(FILT_CYCLES - 1))
    else $error("low flag set without full filter time");
  a_high_filter: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(high_flag_q) |-> $past(high_cond))
    else $error("high flag set without condition");
  a_normal_only: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && !normal |=> low_cnt_q == 16'h0000 && high_cnt_q == 16'h0000)
    else $error("filter ran outside normal state");
  a_comp_disable: assert property (@(posedge clk) disable iff (!rst_n)
    !comp_en && clk_en ##1 clk_en |-> !$rose(low_flag_q) && !$rose(high_flag_q))
    else $error("flag set while comparison disabled");
  a_fault_low: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && low_hit && !low_flag_q && !en_fall |=> !fault_n_q && low_flag_q)
    else $error("fault not pulled low on low flag");
  a_high_off: assert property (@(posedge clk) disable iff (!rst_n)
    high_flag_q |-> duty_scale_q == 16'h0000 || $past(!high_flag_q))
    else $error("outputs on with high flag");
  a_flag_hold: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && low_flag_q && low_s && !en_fall |=> low_flag_q)
    else $error("low flag cleared while condition present");
  a_fault_release: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && sel_tog && !fault_set |=> fault_n_q)
    else $error("fault not released on select toggle");
  a_hybrid_cur: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && hybrid |=> current_scale_q == $past(duty_d))
    else $error("hybrid current not following duty");
  a_aw_pulse: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && s_axi_awready |=> !s_axi_awready)
    else $error("write ready held past handshake");
  a_b_after_aw: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(s_axi_bvalid) |-> $past(s_axi_awready))
    else $error("write response before address handshake");
  a_b_hold: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped before ready");
  a_ar_pulse: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && s_axi_arready |=> !s_axi_arready)
    else $error("read ready held past handshake");
  a_r_after_ar: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(s_axi_rvalid) |-> $past(s_axi_arready))
    else $error("read data before address handshake");
  a_r_hold: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed before ready");
  a_irq_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    status_q == 2'b00 |-> !irq_q)
    else $error("interrupt without status bit");
  a_high_led_off: assert property (@(posedge clk) disable iff (!rst_n)
    high_flag_q |-> led_off_q)
    else $error("leds on with high flag");
  a_low_current: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && low_flag_q |=> current_scale_q < 16'd5001)
    else $error("current not reduced with low flag");
  a_high_zero: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && high_flag_q |=> duty_scale_q == 16'h0000 && current_scale_q == 16'h0000)
    else $error("duty or current left on with high flag");
  a_duty_step: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && !low_flag_q && !high_flag_q && die_temp_c == die_thr + 8'd1
      |=> duty_scale_q == 16'd9775)
    else $error("duty step per degree wrong");
  a_die_cut: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && die_temp_c > die_thr |=> duty_scale_q < 16'd10000)
    else $error("duty not cut above die threshold");
  a_flag_clear: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && low_flag_q && host_clr && !low_s |=> !low_flag_q)
    else $error("low flag kept after clear with condition gone");
  a_en_release: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && en_fall && !fault_set |=> fault_n_q && !low_flag_q && !high_flag_q)
    else $error("enable cycling did not clear faults");
  a_status_sticky: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && status_q[0] && !rd_stat |=> status_q[0])
    else $error("status event lost without read");
  a_freeze_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !clk_en |=> $stable(st_q) && $stable(fault_n_q) && $stable(duty_scale_q))
    else $error("state moved while clock enable low");
endmodule : thermal_led_current_limit

// ==== thermal_params.svh ====
// constants for the thermal led current limit block
// What this block does
// - above the die temperature threshold picked by die_temp_limit_sel, pwm duty drops about 2.25 percent per degree.
// - in hybrid dimming the sink current is lowered along with pwm duty during die temperature reduction.
// - exceeding the low level sets ntc_low_flag and reduces led current.
// - the active low fault output goes low when ntc_low_flag sets.
// - both thermistor thresholds are checked only in normal operation.
// - ntc_high_level_sel uses the same encoding; exceeding it sets ntc_high_flag, turns leds off and pulls fault low.
// - with ntc_comp_enable at 0 no thermistor fault sets; a flag set earlier keeps acting until it clears.
// - a flag clears on reset or enable cycling, or on a clear command or select toggle once its condition is gone.
// - the fault output releases on reset, enable cycling, clear command or select toggle without waiting.
// - each thermistor detection must persist 10 us before its flag sets.
`ifndef THERMAL_PARAMS_SVH
`define THERMAL_PARAMS_SVH
`define CLK_FREQ_HZ      20000000
`define NTC_FILT_TIME_NS 10000
`define NTC_FILT_CYCLES  ((`NTC_FILT_TIME_NS * (`CLK_FREQ_HZ / 1000000) + 999) / 1000)
`define DUTY_STEP_CENTI  225
`define REG_CTRL         32'h00
`define REG_STATUS       32'h04
`define REG_MASK         32'h08
`define REG_TEMP         32'h0c
`define REG_CMD          32'h10
`define CTRL_COMP_EN     0
`define CTRL_HYBRID      1
`define CTRL_DIE_SEL     2
`define CTRL_LOW_SEL     4
`define CTRL_HIGH_SEL    8
`define CMD_CLEAR        0
`define CTRL_RESET       32'h0000_f401
`endif

// ==== thermal_pkg.sv ====
// types for the thermal led current limit block
package thermal_pkg;
  typedef enum logic [2:0] {
    ST_STANDBY = 3'b001,
    ST_STARTUP = 3'b010,
    ST_NORMAL  = 3'b100
  } op_state_t;
endpackage : thermal_pkg
